// [hdl/aeg_map.vh]
// Contract
// [RULE1] Two independent encoder input ports, each with its own present value.
// [RULE2] Each port follows position changes up to 4 kHz without losing any.
// [RULE3] Input words are Gray code, converted to binary before any use.
// [RULE4] The encoder must deliver its position in Gray code only.
// [RULE5] Per port output mode: decimal-coded position or degrees over 360.
// [RULE6] Per port resolution 8, 10 or 12 bits: 0-255, 0-1023, 0-4095.
// [RULE7] Software sets each port's resolution equal to its encoder's.
// [RULE8] Request a routine when a present value equals a stored target.
// [RULE9] Request a routine when a present value lies within a stored range.
// [RULE10] Origin compensation: any encoder position may become the zero point.
// [RULE11] Per port bit-zero indicator lit while input bit 0 is set.
// [RULE12] Per port up indicator lit when a new sample exceeds the last.
// [RULE13] Per port down indicator lit when a new sample is below the last.
// [RULE14] Error indicator lit while the stored configuration is invalid.
// [RULE15] Resolution field codes: 00 for 8, 01 for 10, 02 for 12 bits.
// [RULE16] Each present value reaches the host as a four-digit decimal word.
// [RULE17] Each port holds 48 target values, each with a routine number.
// [RULE18] Each port holds 8 ranges with upper, lower limit and routine number.
// [RULE19] Binary bit is XOR of Gray bits at or above it; unused bits zero.
// [RULE20] Inputs pass two flip-flop stages before conversion.
`ifndef AEG_MAP_VH
`define AEG_MAP_VH

`define AEG_GRAY_W      12
`define AEG_PV_W        16

`define AEG_RES_8       8'h00
`define AEG_RES_10      8'h01
`define AEG_RES_12      8'h02

`define AEG_MASK_8      12'h0ff
`define AEG_MASK_10     12'h3ff
`define AEG_MASK_12     12'hfff

`define AEG_DEG_FULL    9'd360
`define AEG_HALF_8      21'h000080
`define AEG_HALF_10     21'h000200
`define AEG_HALF_12     21'h000800

`define AEG_N_TGT       7'd48
`define AEG_TGT_LAST    6'd47
`define AEG_RNG_LAST    6'd7

// Word addresses on the register bus
`define AEG_A_CFG0      8'h00
`define AEG_A_CFG1      8'h01
`define AEG_A_ORG0      8'h02
`define AEG_A_ORG1      8'h03
`define AEG_A_CTRL      8'h04
`define AEG_A_STAT      8'h05
`define AEG_A_PV0       8'h06
`define AEG_A_PV1       8'h07
`define AEG_A_RAW0      8'h08
`define AEG_A_RAW1      8'h09
`define AEG_A_RNG_HI    3'b001
`define AEG_A_TGT0_HI   2'b01
`define AEG_A_TGT1_HI   2'b10

// Field positions
`define AEG_CFG_MODE    8
`define AEG_EN_BIT      31
`define AEG_RT_LO       16

// Reset values
`define AEG_CFG_RST     8'h00
`define AEG_ORG_RST     12'h000

`endif

// [hdl/aeg_gray_conv.v]
`timescale 1ns/1ns
`include "aeg_map.vh"
module aeg_gray_conv (
    input  wire                   clock,
    input  wire                   sys_rst,
    input  wire [`AEG_GRAY_W-1:0] gray_in,
    input  wire [`AEG_GRAY_W-1:0] res_mask,
    output reg  [`AEG_GRAY_W-1:0] bin_out,
    output reg                    lsb_out
);

reg  [`AEG_GRAY_W-1:0] sync_a;
reg  [`AEG_GRAY_W-1:0] sync_b;
wire [`AEG_GRAY_W-1:0] masked;
wire [`AEG_GRAY_W-1:0] bin_c;

assign masked = sync_b & res_mask; // [RULE19]

genvar i;
generate
    for (i = 0; i < `AEG_GRAY_W; i = i + 1) begin : g_bit
        if (i == `AEG_GRAY_W - 1) begin : g_top
            assign bin_c[i] = masked[i];
        end else begin : g_low
            assign bin_c[i] = masked[i] ^ bin_c[i+1]; // [RULE3] [RULE19]
        end
    end
endgenerate

always @(posedge clock) begin
    if (sys_rst) begin
        sync_a  <= 12'h000;
        sync_b  <= 12'h000;
        bin_out <= 12'h000;
        lsb_out <= 1'b0;
    end else begin
        sync_a  <= gray_in; // [RULE20]
        sync_b  <= sync_a; // [RULE20]
        bin_out <= bin_c;
        lsb_out <= sync_b[0]; // [RULE11]
    end
end

endmodule

// [hdl/aeg_top.v]
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "aeg_map.vh"
module aeg_top (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [11:0] port1_connector,
    input  wire [11:0] port2_connector,
    output wire        port1_lsb_indicator,
    output wire        port2_lsb_indicator,
    output wire        port1_up_indicator,
    output wire        port2_up_indicator,
    output wire        port1_down_indicator,
    output wire        port2_down_indicator,
    output reg         error_indicator,
    output wire [31:0] present_position_value,
    output reg         req_valid,
    output reg         req_port,
    output reg         req_kind,
    output reg  [7:0]  req_routine
);

localparam ST_IDLE = 3'b001;
localparam ST_TGT  = 3'b010;
localparam ST_RNG  = 3'b100;

reg  [7:0]  cfg_res  [0:1];
reg         cfg_mode [0:1];
reg  [11:0] origin   [0:1];
reg  [31:0] tgt_mem  [0:95];
reg  [31:0] rng_mem  [0:31];
reg  [95:0] tgt_en;
reg  [15:0] rng_en;
reg         ack;
reg  [2:0]  state;
reg         scan_port;
reg  [5:0]  scan_idx;
reg  [15:0] scan_val;
reg  [1:0]  pend;

wire [23:0] gray_all;
wire [23:0] bin_all;
wire [23:0] raw_pos;
wire [1:0]  lsb_all;
wire [1:0]  up_all;
wire [1:0]  down_all;
wire [1:0]  chg_all;
wire [1:0]  cfg_ok;

reg  [31:0] rd_mux;
reg  [31:0] wr_val;
reg  [1:0]  take;
reg  [6:0]  tgt_ridx;
reg  [4:0]  rng_ridx;
reg  [31:0] tgt_word;
reg  [31:0] rng_lim;
reg  [31:0] rng_rt;

wire        tgt_hit;
wire [6:0]  tgt_widx;
wire        rng_hit;
wire        wr_go;

function [11:0] res_mask_of;
    input [7:0] code;
    begin
        case (code)
            `AEG_RES_8:  res_mask_of = `AEG_MASK_8; // [RULE15]
            `AEG_RES_10: res_mask_of = `AEG_MASK_10; // [RULE15]
            default:     res_mask_of = `AEG_MASK_12; // [RULE6]
        endcase
    end
endfunction

// Shift-and-add-3 conversion of 12-bit binary to four decimal digits
function [15:0] to_bcd;
    input [11:0] val;
    integer      k;
    reg   [27:0] acc;
    begin
        acc = {16'h0000, val};
        for (k = 0; k < 12; k = k + 1) begin
            if (acc[15:12] > 4'd4) acc[15:12] = acc[15:12] + 4'd3;
            if (acc[19:16] > 4'd4) acc[19:16] = acc[19:16] + 4'd3;
            if (acc[23:20] > 4'd4) acc[23:20] = acc[23:20] + 4'd3;
            if (acc[27:24] > 4'd4) acc[27:24] = acc[27:24] + 4'd3;
            acc = {acc[26:0], 1'b0};
        end
        to_bcd = acc[27:12];
    end
endfunction

assign gray_all = {port2_connector, port1_connector};

genvar p;
generate
    for (p = 0; p < 2; p = p + 1) begin : g_port // [RULE1]
        wire [11:0] mask;
        wire [11:0] bin;
        wire [11:0] pos;
        wire [20:0] scaled;
        reg  [8:0]  deg;
        wire [11:0] shown;
        wire [15:0] next_pv;
        reg  [15:0] pv;
        reg  [11:0] prev_bin;
        reg         up;
        reg         down;
        reg         chg;

        assign mask = res_mask_of(cfg_res[p]);
        assign cfg_ok[p] = (cfg_res[p] <= `AEG_RES_12); // [RULE14]

        aeg_gray_conv u_conv (
            .clock    (clock),
            .sys_rst  (sys_rst),
            .gray_in  (gray_all[p*12 +: 12]),
            .res_mask (mask),
            .bin_out  (bin),
            .lsb_out  (lsb_all[p])
        );

        assign pos = (bin - origin[p]) & mask; // [RULE10]
        assign scaled = {9'h000, pos} * 21'd360;

        // Rounded to the nearest degree; a full turn folds back to zero
        always @* begin
            case (cfg_res[p])
                `AEG_RES_8: begin
                    deg = scaled_sum(scaled, `AEG_HALF_8, 2'd0);
                end
                `AEG_RES_10: begin
                    deg = scaled_sum(scaled, `AEG_HALF_10, 2'd1);
                end
                default: begin
                    deg = scaled_sum(scaled, `AEG_HALF_12, 2'd2);
                end
            endcase
        end

        assign shown = cfg_mode[p] ? {3'b000, deg} : pos; // [RULE5]
        assign next_pv = to_bcd(shown); // [RULE16]

        always @(posedge clock) begin
            if (sys_rst) begin
                pv       <= 16'h0000;
                prev_bin <= 12'h000;
                up       <= 1'b0;
                down     <= 1'b0;
                chg      <= 1'b0;
            end else begin
                chg <= 1'b0;
                if (cfg_ok[p]) begin
                    pv  <= next_pv;
                    chg <= (next_pv != pv); // [RULE2]
                    if (bin != prev_bin) begin
                        prev_bin <= bin;
                        up       <= (bin > prev_bin); // [RULE12]
                        down     <= (bin < prev_bin); // [RULE13]
                    end
                end
            end
        end

        assign bin_all[p*12 +: 12] = bin;
        assign raw_pos[p*12 +: 12] = pos;
        assign present_position_value[p*16 +: 16] = pv;
        assign up_all[p] = up;
        assign down_all[p] = down;
        assign chg_all[p] = chg;
    end
endgenerate

function [8:0] scaled_sum;
    input [20:0] prod;
    input [20:0] half;
    input [1:0]  sel;
    reg   [20:0] s;
    reg   [8:0]  d;
    begin
        s = prod + half;
        case (sel)
            2'd0:    d = s[16:8];
            2'd1:    d = s[18:10];
            default: d = s[20:12];
        endcase
        scaled_sum = (d >= `AEG_DEG_FULL) ? 9'd0 : d; // [RULE5]
    end
endfunction

assign port1_lsb_indicator  = lsb_all[0]; // [RULE11]
assign port2_lsb_indicator  = lsb_all[1]; // [RULE11]
assign port1_up_indicator   = up_all[0];
assign port2_up_indicator   = up_all[1];
assign port1_down_indicator = down_all[0];
assign port2_down_indicator = down_all[1];

// Register bus: one wait cycle, then the answer
assign avs_waitrequest = (avs_read | avs_write) & ~ack;
assign wr_go = avs_write & ack;

assign tgt_hit = ((avs_address[7:6] == `AEG_A_TGT0_HI) ||
                  (avs_address[7:6] == `AEG_A_TGT1_HI)) &&
                 ({1'b0, avs_address[5:0]} < `AEG_N_TGT); // [RULE17]
assign tgt_widx = avs_address[7] ?
                  (`AEG_N_TGT + {1'b0, avs_address[5:0]}) :
                  {1'b0, avs_address[5:0]};
assign rng_hit = (avs_address[7:5] == `AEG_A_RNG_HI); // [RULE18]

always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
        `AEG_A_CFG0: rd_mux = {23'h0, cfg_mode[0], cfg_res[0]};
        `AEG_A_CFG1: rd_mux = {23'h0, cfg_mode[1], cfg_res[1]};
        `AEG_A_ORG0: rd_mux = {20'h0, origin[0]};
        `AEG_A_ORG1: rd_mux = {20'h0, origin[1]};
        `AEG_A_STAT: rd_mux = {24'h0, down_all, up_all, lsb_all,
                               state != ST_IDLE, error_indicator};
        `AEG_A_PV0:  rd_mux = {16'h0, present_position_value[15:0]};
        `AEG_A_PV1:  rd_mux = {16'h0, present_position_value[31:16]};
        `AEG_A_RAW0: rd_mux = {20'h0, raw_pos[11:0]};
        `AEG_A_RAW1: rd_mux = {20'h0, raw_pos[23:12]};
        default: begin
            if (tgt_hit) begin
                rd_mux = tgt_mem[tgt_widx];
                rd_mux[`AEG_EN_BIT] = tgt_en[tgt_widx];
            end else if (rng_hit) begin
                rd_mux = rng_mem[avs_address[4:0]];
                if (avs_address[0])
                    rd_mux[`AEG_EN_BIT] = rng_en[avs_address[4:1]];
            end
        end
    endcase
end

// Byte lanes not enabled keep their present content
always @* begin
    wr_val = rd_mux;
    if (avs_byteenable[0]) wr_val[7:0]   = avs_writedata[7:0];
    if (avs_byteenable[1]) wr_val[15:8]  = avs_writedata[15:8];
    if (avs_byteenable[2]) wr_val[23:16] = avs_writedata[23:16];
    if (avs_byteenable[3]) wr_val[31:24] = avs_writedata[31:24];
end

always @(posedge clock) begin
    if (sys_rst) begin
        ack             <= 1'b0;
        avs_readdata    <= 32'h00000000;
        cfg_res[0]      <= `AEG_CFG_RST;
        cfg_res[1]      <= `AEG_CFG_RST;
        cfg_mode[0]     <= 1'b0;
        cfg_mode[1]     <= 1'b0;
        origin[0]       <= `AEG_ORG_RST;
        origin[1]       <= `AEG_ORG_RST;
        tgt_en          <= 96'h0;
        rng_en          <= 16'h0000;
        error_indicator <= 1'b0;
    end else begin
        ack <= (avs_read | avs_write) & ~ack;
        if (avs_read & ~ack)
            avs_readdata <= rd_mux;
        error_indicator <= ~&cfg_ok; // [RULE14]
        if (wr_go) begin
            case (avs_address)
                `AEG_A_CFG0: begin
                    cfg_res[0]  <= wr_val[7:0]; // [RULE6] [RULE15]
                    cfg_mode[0] <= wr_val[`AEG_CFG_MODE]; // [RULE5]
                end
                `AEG_A_CFG1: begin
                    cfg_res[1]  <= wr_val[7:0]; // [RULE6] [RULE15]
                    cfg_mode[1] <= wr_val[`AEG_CFG_MODE]; // [RULE5]
                end
                `AEG_A_ORG0: origin[0] <= wr_val[11:0]; // [RULE10]
                `AEG_A_ORG1: origin[1] <= wr_val[11:0]; // [RULE10]
                `AEG_A_CTRL: begin
                    if (wr_val[0]) origin[0] <= bin_all[11:0]; // [RULE10]
                    if (wr_val[1]) origin[1] <= bin_all[23:12]; // [RULE10]
                end
                default: begin
                    if (tgt_hit) begin
                        tgt_mem[tgt_widx] <= wr_val; // [RULE17]
                        tgt_en[tgt_widx]  <= wr_val[`AEG_EN_BIT];
                    end else if (rng_hit) begin
                        rng_mem[avs_address[4:0]] <= wr_val; // [RULE18]
                        if (avs_address[0])
                            rng_en[avs_address[4:1]] <=
                                wr_val[`AEG_EN_BIT];
                    end
                end
            endcase
        end
    end
end

// Comparison scan: each port's latest changed value is checked against all of that port's entries
always @* begin
    take = 2'b00;
    if (state == ST_IDLE) begin
        if (pend[0])
            take = 2'b01;
        else if (pend[1])
            take = 2'b10;
    end
    tgt_ridx = scan_port ? (`AEG_N_TGT + {1'b0, scan_idx}) :
                           {1'b0, scan_idx};
    rng_ridx = {scan_port, scan_idx[2:0], 1'b0};
    tgt_word = tgt_mem[tgt_ridx];
    rng_lim  = rng_mem[rng_ridx];
    rng_rt   = rng_mem[rng_ridx | 5'h01];
end

always @(posedge clock) begin
    if (sys_rst) begin
        state       <= ST_IDLE;
        scan_port   <= 1'b0;
        scan_idx    <= 6'd0;
        scan_val    <= 16'h0000;
        pend        <= 2'b00;
        req_valid   <= 1'b0;
        req_port    <= 1'b0;
        req_kind    <= 1'b0;
        req_routine <= 8'h00;
    end else begin
        pend      <= (pend & ~take) | chg_all; // [RULE2]
        req_valid <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (take != 2'b00) begin
                    scan_port <= take[1];
                    scan_val  <= take[1] ?
                                 present_position_value[31:16] :
                                 present_position_value[15:0];
                    scan_idx  <= 6'd0;
                    state     <= ST_TGT;
                end
            end
            ST_TGT: begin
                if (tgt_en[tgt_ridx] && tgt_word[15:0] == scan_val) begin
                    req_valid   <= 1'b1; // [RULE8]
                    req_port    <= scan_port;
                    req_kind    <= 1'b0;
                    req_routine <= tgt_word[`AEG_RT_LO +: 8];
                end
                if (scan_idx == `AEG_TGT_LAST) begin
                    scan_idx <= 6'd0;
                    state    <= ST_RNG;
                end else begin
                    scan_idx <= scan_idx + 6'd1;
                end
            end
            ST_RNG: begin
                if (rng_en[rng_ridx[4:1]] && scan_val >= rng_lim[15:0] &&
                    scan_val <= rng_lim[31:16]) begin
                    req_valid   <= 1'b1; // [RULE9]
                    req_port    <= scan_port;
                    req_kind    <= 1'b1;
                    req_routine <= rng_rt[7:0];
                end
                if (scan_idx == `AEG_RNG_LAST) begin
                    scan_idx <= 6'd0;
                    state    <= ST_IDLE;
                end else begin
                    scan_idx <= scan_idx + 6'd1;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

endmodule

// [bench/aeg_enc_model.sv]
`timescale 1ns/1ns
module aeg_enc_model (
    input  wire [11:0] pos,
    input  wire [11:0] mask,
    output wire [11:0] code
);
    // Pins beyond the encoder's resolution are unconnected and read low
    assign code = (pos ^ (pos >> 1)) & mask;
endmodule

// [bench/aeg_top_checker.sv]
`timescale 1ns/1ns
module aeg_top_checker (
    input wire        clock,
    input wire        sys_rst,
    input wire [7:0]  avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire        avs_waitrequest,
    input wire [11:0] port1_connector,
    input wire [11:0] port2_connector,
    input wire        port1_lsb_indicator,
    input wire        port2_lsb_indicator,
    input wire        port1_up_indicator,
    input wire        port1_down_indicator,
    input wire        port2_up_indicator,
    input wire        port2_down_indicator,
    input wire        error_indicator,
    input wire [31:0] present_position_value,
    input wire        req_valid
);
    reg [3:0] age;
    reg [3:0] quiet;
    reg [7:0] since;

    function automatic logic digits_ok(input logic [31:0] v);
        integer i;
        digits_ok = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            if (v[4*i +: 4] > 4'h9)
                digits_ok = 1'b0;
    endfunction

    always @(posedge clock) begin
        if (sys_rst) begin
            age <= 4'h0;
            quiet <= 4'h0;
            since <= 8'hff;
        end else begin
            if (age != 4'hf)
                age <= age + 4'h1;
            if ($changed({port1_connector, port2_connector}) || avs_write)
                quiet <= 4'h0;
            else if (quiet != 4'hf)
                quiet <= quiet + 4'h1;
            if ($changed(present_position_value))
                since <= 8'h00;
            else if (since != 8'hff)
                since <= since + 8'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence bad_cfg_write;
        avs_write && !avs_waitrequest && avs_address == 8'h00 &&
        avs_byteenable[0] && avs_writedata[7:0] > 8'h02;
    endsequence

    lsb1_sync_a: assert property (
        age > 4'h3 |-> port1_lsb_indicator == $past(port1_connector[0], 3))
        else $error("port1 bit-zero indicator wrong");
    lsb2_sync_a: assert property (
        age > 4'h3 |-> port2_lsb_indicator == $past(port2_connector[0], 3))
        else $error("port2 bit-zero indicator wrong");
    dir1_excl_a: assert property (
        !(port1_up_indicator && port1_down_indicator))
        else $error("port1 up and down both lit");
    dir2_excl_a: assert property (
        !(port2_up_indicator && port2_down_indicator))
        else $error("port2 up and down both lit");
    pv_quiet_a: assert property (
        quiet > 4'h8 |-> $stable(present_position_value) &&
        $stable({port1_up_indicator, port1_down_indicator}))
        else $error("position moved with quiet inputs");
    bcd_word_a: assert property (
        digits_ok(present_position_value))
        else $error("position value not decimal coded");
    err_set_a: assert property (
        bad_cfg_write |-> ##[1:3] error_indicator)
        else $error("error flag not raised by bad resolution");
    err_hold_a: assert property (
        quiet > 4'h8 |-> $stable(error_indicator))
        else $error("error flag moved without a write");
    req_cause_a: assert property (
        req_valid |-> since < 8'd200)
        else $error("routine request without position change");
endmodule

bind aeg_top aeg_top_checker chk (.*);

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic        clock;
    logic        sys_rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    logic [11:0] pos1, pos2, mask1, mask2;
    wire  [11:0] code1, code2;
    wire  [31:0] ppv;
    wire         lsb1, lsb2, up1, up2, dn1, dn2, err, rv, rp, rk;
    wire  [7:0]  rr;
    integer      num_errors, n_checks, i;
    logic [31:0] q;
    logic [11:0] deg_in [3] = '{12'd3, 12'd255, 12'd128};
    logic [15:0] deg_pv [3] = '{16'h0004, 16'h0359, 16'h0180};
    logic [15:0] res_pv [3] = '{16'h0255, 16'h1023, 16'h4095};

    always #50 clock = ~clock;

    aeg_enc_model enc1 (.pos(pos1), .mask(mask1), .code(code1));
    aeg_enc_model enc2 (.pos(pos2), .mask(mask2), .code(code2));
    aeg_top dut (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port1_connector(code1),
        .port2_connector(code2), .port1_lsb_indicator(lsb1),
        .port2_lsb_indicator(lsb2), .port1_up_indicator(up1),
        .port2_up_indicator(up2), .port1_down_indicator(dn1),
        .port2_down_indicator(dn2), .error_indicator(err),
        .present_position_value(ppv), .req_valid(rv), .req_port(rp),
        .req_kind(rk), .req_routine(rr));

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input integer n);
        repeat (n) @(posedge clock);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        integer n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n = n + 1;
            @(posedge clock);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            num_errors = num_errors + 1;
            $display("ERROR %0t: bus access hung", $time);
            conclude;
        end
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        check(q, e);
    endtask

    task automatic pv_chk(input logic p, input logic [15:0] e);
        tick(6);
        check({16'h0, p ? ppv[31:16] : ppv[15:0]}, {16'h0, e});
    endtask

    task automatic wait_req(input logic p, input logic k,
                            input logic [7:0] r);
        integer n;
        n = 0;
        while (rv !== 1'b1 && n < 300) begin
            n = n + 1;
            @(posedge clock);
        end
        check({21'h0, rv, rp, rk, rr}, {21'h0, 1'b1, p, k, r});
        if (rv !== 1'b1)
            conclude;
        @(posedge clock);
    endtask

    function automatic logic [15:0] bcd(input integer v);
        bcd = {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction

    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        pos1 = 12'h000;
        pos2 = 12'h000;
        mask1 = 12'h0ff;
        mask2 = 12'h0ff;
        num_errors = 0;
        n_checks = 0;
        tick(4);
        sys_rst <= 1'b0;
        tick(1);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h02, 32'h0);
        rd_chk(8'h70, 32'h0);
        pv_chk(1'b0, 16'h0000);
        $display("reset test done");
        pos1 <= 12'd201;
        pos2 <= 12'd37;
        pv_chk(1'b0, 16'h0201);
        pv_chk(1'b1, 16'h0037);
        check({lsb2, lsb1, up2, dn2, up1, dn1}, 6'b111010);
        pos1 <= 12'd200;
        pv_chk(1'b0, 16'h0200);
        check({lsb1, up1, dn1}, 3'b001);
        rd_chk(8'h08, 32'd200);
        for (i = 1; i < 6; i = i + 1) begin
            pos1 <= 12'(i * 45);
            pv_chk(1'b0, bcd(i * 45));
        end
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h01, i);
            mask2 <= ~(12'hfff << (8 + 2 * i));
            pos2 <= ~(12'hfff << (8 + 2 * i));
            pv_chk(1'b1, res_pv[i]);
            rd_chk(8'h01, i);
            wr(8'h01, 32'h100 + i);
            pv_chk(1'b1, i ? 16'h0000 : 16'h0359);
        end
        wr(8'h01, 32'h0);
        mask2 <= 12'h0ff;
        pos2 <= 12'd37;
        $display("conversion test done");
        wr(8'h00, 32'h100);
        for (i = 0; i < 3; i = i + 1) begin
            pos1 <= deg_in[i];
            pv_chk(1'b0, deg_pv[i]);
        end
        bus(1'b1, 8'h00, 32'hffff_0003, 4'h2);
        rd_chk(8'h00, 32'h0);
        check(err, 1'b0);
        $display("degree test done");
        pos1 <= 12'd100;
        tick(6);
        wr(8'h04, 32'h1);
        pv_chk(1'b0, 16'h0000);
        rd_chk(8'h02, 32'd100);
        pos1 <= 12'd98;
        pv_chk(1'b0, 16'h0254);
        wr(8'h02, 32'h0);
        wr(8'h04, 32'h2);
        rd_chk(8'h03, 32'd37);
        rd_chk(8'h09, 32'h0);
        rd_chk(8'h07, 32'h0);
        wr(8'h03, 32'h0);
        $display("origin test done");
        wr(8'h00, 32'h3);
        pos1 <= 12'd50;
        tick(3);
        check(err, 1'b1);
        pv_chk(1'b0, 16'h0098);
        wr(8'h00, 32'h0);
        pv_chk(1'b0, 16'h0050);
        check(err, 1'b0);
        $display("error test done");
        for (i = 0; i < 2; i = i + 1) begin
            wr(i ? 8'h6f : 8'h40, {8'h80, 8'(8'h20 + i), 16'h0077});
            pos1 <= 12'd77;
            wait_req(1'b0, 1'b0, 8'(8'h20 + i));
            wr(i ? 8'h6f : 8'h40, 32'h0);
            pos1 <= 12'd10;
            tick(150);
        end
        wr(8'h3e, 32'h0020_0010);
        wr(8'h3f, 32'h8000_0055);
        wr(8'h80, 32'h8031_0015);
        pos2 <= 12'd15;
        wait_req(1'b1, 1'b0, 8'h31);
        wait_req(1'b1, 1'b1, 8'h55);
        tick(150);
        pos2 <= 12'd20;
        wait_req(1'b1, 1'b1, 8'h55);
        wr(8'h3f, 32'h0);
        $display("request test done");
        conclude;
    end
endmodule
